// ### logic/levpwm_top.sv
/*
  Levitation coil PWM controller with a missing-magnet watchdog.
  Assumes a converted sensor sample and a comparator level, both synchronous to clk.
*/
`timescale 1ns/1ps
`include "levpwm_params.svh"

module levpwm_top #(
  parameter int SAMPLE_W = `LEVPWM_SAMPLE_W,
  parameter int unsigned PULSE_LIMIT_CYCLES = `LEVPWM_PULSE_LIMIT_CYCLES,
  parameter int unsigned HOLD_CYCLES = `LEVPWM_HOLD_CYCLES,
  parameter int unsigned STARTUP_CYCLES = `LEVPWM_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [SAMPLE_W-1:0] sensor_sample,
  input wire logic sensor_below_threshold,
  output logic coil_pwm_output,
  output levpwm_pkg::levpwm_status_t status
);
  import levpwm_pkg::*;

  // ***************************************************
  // PWM generator
  // ***************************************************
  logic duty_compare;

  levpwm_ramp #(
    .SAMPLE_W(SAMPLE_W)
  ) u_ramp (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .sample(sensor_sample),
    .duty_compare(duty_compare)
  );

  // ***************************************************
  // Watchdog state
  // ***************************************************
  levpwm_state_t state;
  levpwm_state_t next_state;
  logic [`LEVPWM_TIMER_W-1:0] timer;
  logic [`LEVPWM_TIMER_W-1:0] next_timer;
  logic [`LEVPWM_TIMER_W-1:0] pulse_width;
  logic [`LEVPWM_TIMER_W-1:0] next_pulse_width;
  logic pulse_edge_flop;
  logic next_pulse_edge_flop;
  logic pulse_over_limit;
  logic hold_done;
  logic startup_done;
  logic next_coil;
  levpwm_status_t next_status;

  localparam logic [`LEVPWM_TIMER_W-1:0] PULSE_LIMIT = PULSE_LIMIT_CYCLES[`LEVPWM_TIMER_W-1:0];
  localparam logic [`LEVPWM_TIMER_W-1:0] HOLD_LAST = HOLD_CYCLES[`LEVPWM_TIMER_W-1:0] - 1'b1;
  localparam logic [`LEVPWM_TIMER_W-1:0] START_LAST =
    STARTUP_CYCLES[`LEVPWM_TIMER_W-1:0] - 1'b1;

  // ***************************************************
  // Helpers
  // ***************************************************
  // Timers never wrap: every caller stops or clears them at their end value
  function automatic logic [`LEVPWM_TIMER_W-1:0] timer_step(
    input logic [`LEVPWM_TIMER_W-1:0] value
  );
    return value + {{(`LEVPWM_TIMER_W-1){1'b0}}, 1'b1};
  endfunction : timer_step

  function automatic logic state_is_run(
    input levpwm_state_t value
  );
    return value == LEVPWM_RUN;
  endfunction : state_is_run

  function automatic logic state_is_shutdown(
    input levpwm_state_t value
  );
    return value == LEVPWM_SHUTDOWN;
  endfunction : state_is_shutdown

  function automatic logic state_is_startup(
    input levpwm_state_t value
  );
    return value == LEVPWM_STARTUP;
  endfunction : state_is_startup

  // ***************************************************
  // Pulse width watch
  // ***************************************************
  assign pulse_over_limit = (pulse_width == PULSE_LIMIT);

  always_comb
  begin
    next_pulse_edge_flop = duty_compare;
    next_pulse_width = pulse_width;
    // Width is measured on the raw comparator so a stuck-high pulse is caught
    if (!duty_compare)
    begin
      next_pulse_width = '0;
    end
    else if (!pulse_edge_flop)
    begin
      // Rising edge of a pulse starts a fresh count
      next_pulse_width = {{(`LEVPWM_TIMER_W-1){1'b0}}, 1'b1};
    end
    else if (!pulse_over_limit)
    begin
      next_pulse_width = timer_step(pulse_width);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pulse_width <= '0;
      pulse_edge_flop <= 1'b0;
    end
    else if (ce)
    begin
      pulse_width <= next_pulse_width;
      pulse_edge_flop <= next_pulse_edge_flop;
    end
  end

  // ***************************************************
  // Watchdog sequencing
  // ***************************************************
  assign hold_done = (timer == HOLD_LAST);
  assign startup_done = (timer == START_LAST);

  always_comb
  begin
    next_state = state;
    next_timer = timer;
    unique case (state)
      LEVPWM_STARTUP:
      begin
        // Blanking counts from reset release, whatever the sensor shows
        if (startup_done)
        begin
          next_state = LEVPWM_RUN;
          next_timer = '0;
        end
        else
        begin
          next_timer = timer_step(timer);
        end
      end
      LEVPWM_RUN:
      begin
        next_timer = '0;
        if (duty_compare && pulse_over_limit)
        begin
          next_state = LEVPWM_SHUTDOWN;
        end
      end
      LEVPWM_SHUTDOWN:
      begin
        // Any break in the comparator restarts the half second
        if (!sensor_below_threshold)
        begin
          next_timer = '0;
        end
        else if (hold_done)
        begin
          next_state = LEVPWM_RUN;
          next_timer = '0;
        end
        else
        begin
          next_timer = timer_step(timer);
        end
      end
      default:
      begin
        // An upset state code fails safe with the drive off
        next_state = LEVPWM_SHUTDOWN;
        next_timer = '0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= LEVPWM_STARTUP;
      timer <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ***************************************************
  // Coil drive and status
  // ***************************************************
  always_comb
  begin
    // Run is needed on both sides of the edge, so the entry cycle stays low
    next_coil = duty_compare && state_is_run(next_state) && state_is_run(state);
    next_status.coil_pwm_output = next_coil;
    next_status.drive_enabled = state_is_run(next_state);
    next_status.shutdown_latch = state_is_shutdown(next_state);
    next_status.startup_blank = state_is_startup(next_state);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      coil_pwm_output <= 1'b0;
      status <= `LEVPWM_STATUS_RESET;
    end
    else if (ce)
    begin
      coil_pwm_output <= next_coil;
      status <= next_status;
    end
  end

endmodule : levpwm_top

// ### logic/levpwm_params.svh
/*
  Constants for the levitation PWM controller with watchdog.
  Assumes a 125 MHz clock; included by bare name from the design files.
*/
`ifndef LEVPWM_PARAMS_SVH
`define LEVPWM_PARAMS_SVH

// ***************************************************
// Timing
// ***************************************************
`define LEVPWM_CLK_HZ 125000000
`define LEVPWM_HOLD_MS 500
`define LEVPWM_STARTUP_MS 500
`define LEVPWM_HOLD_CYCLES ((`LEVPWM_CLK_HZ / 1000) * `LEVPWM_HOLD_MS)
`define LEVPWM_STARTUP_CYCLES ((`LEVPWM_CLK_HZ / 1000) * `LEVPWM_STARTUP_MS)
`define LEVPWM_PULSE_LIMIT_CYCLES 8000

// ***************************************************
// Widths
// ***************************************************
`define LEVPWM_SAMPLE_W 8
`define LEVPWM_TIMER_W 32

// ***************************************************
// Reset values
// ***************************************************
`define LEVPWM_STATUS_RESET 4'h1

`endif

// ### logic/levpwm_pkg.sv
/*
  Types shared by the levitation PWM controller.
  Assumes levpwm_params.svh is on the include path.
*/
`include "levpwm_params.svh"

package levpwm_pkg;

  typedef enum logic [2:0] {
    LEVPWM_STARTUP = 3'b001,
    LEVPWM_RUN = 3'b010,
    LEVPWM_SHUTDOWN = 3'b100
  } levpwm_state_t;

  typedef struct packed {
    logic coil_pwm_output;
    logic drive_enabled;
    logic shutdown_latch;
    logic startup_blank;
  } levpwm_status_t;

endpackage : levpwm_pkg

// ### logic/levpwm_ramp.sv
/*
  Free running PWM ramp counter with a digital duty comparator.
  Assumes the sample input is synchronous to clk.
*/
`timescale 1ns/1ps
`include "levpwm_params.svh"

module levpwm_ramp #(
  parameter int SAMPLE_W = `LEVPWM_SAMPLE_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic duty_compare
);
  import levpwm_pkg::*;

  logic [SAMPLE_W-1:0] pwm_ramp_counter;
  logic [SAMPLE_W-1:0] next_counter;
  logic next_compare;

  always_comb
  begin
    next_counter = pwm_ramp_counter + {{(SAMPLE_W-1){1'b0}}, 1'b1};
    // Full scale compares high on every step, so max input gives full on
    next_compare = (pwm_ramp_counter < sample) || (&sample);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pwm_ramp_counter <= '0;
      duty_compare <= 1'b0;
    end
    else if (ce)
    begin
      pwm_ramp_counter <= next_counter;
      duty_compare <= next_compare;
    end
  end

endmodule : levpwm_ramp

// ### dv/levpwm_properties.sv
/* Port checker for levpwm_top.
   Assumes the bind hands on the top's count parameters. */
`timescale 1ns/1ps
// ****
// Checker
// ****
module levpwm_chk #(
  parameter int unsigned PULSE_LIMIT_CYCLES = 300,
  parameter int unsigned HOLD_CYCLES = 50,
  parameter int unsigned STARTUP_CYCLES = 40
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] sensor_sample,
  input wire logic sensor_below_threshold,
  input wire logic coil_pwm_output,
  input wire levpwm_pkg::levpwm_status_t status
);
  import levpwm_pkg::*;
  int unsigned hi, bc, up, next_hi, next_bc, next_up;
  always_comb
  begin
    next_hi = !ce ? hi : coil_pwm_output ? hi + 1 : 0;
    next_bc = !ce ? bc : sensor_below_threshold ? bc + 1 : 0;
    next_up = (ce && up < STARTUP_CYCLES) ? up + 1 : up;
  end
  always_ff @(posedge clk)
  begin
    hi <= resetn ? next_hi : 0;
    bc <= resetn ? next_bc : 0;
    up <= resetn ? next_up : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_FULL_ON: assert property (ce && sensor_sample == 8'hff && status.drive_enabled ##1
    ce && sensor_sample == 8'hff && status.drive_enabled
    |=> coil_pwm_output || status.shutdown_latch) else $error("coil not full on");
  AST_ZERO_OFF: assert property (ce && sensor_sample == 8'h00 ##1 ce |=> !coil_pwm_output)
    else $error("coil high at zero reading");
  AST_RISE_CAUSE: assert property ($rose(coil_pwm_output) && $past(ce) && $past(ce, 2)
    |-> $past(sensor_sample, 2) != 8'h00) else $error("coil rose without duty");
  AST_PULSE_LIMIT: assert property (hi <= PULSE_LIMIT_CYCLES + 2)
    else $error("pulse outlived the limit");
  AST_HOLD: assert property ($fell(status.shutdown_latch) |-> bc >= HOLD_CYCLES)
    else $error("latch cleared early");
  AST_STARTUP: assert property (up < STARTUP_CYCLES |-> status.startup_blank)
    else $error("startup blanking ended early");
  AST_LATCH_LOW: assert property (status.shutdown_latch |-> !coil_pwm_output)
    else $error("coil high while latched");
  AST_BLANK_LOW: assert property (status.startup_blank |-> !coil_pwm_output)
    else $error("coil high while blanked");
  AST_STATUS_COIL: assert property (status.coil_pwm_output == coil_pwm_output)
    else $error("status coil bit differs from coil");
  AST_ONE_MODE: assert property ($onehot({status.drive_enabled, status.shutdown_latch,
    status.startup_blank})) else $error("status mode bits not one hot");
endmodule : levpwm_chk
bind levpwm_top levpwm_chk #(.PULSE_LIMIT_CYCLES(PULSE_LIMIT_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES)) u_levpwm_chk (.clk(clk),
  .resetn(resetn), .ce(ce), .sensor_sample(sensor_sample),
  .sensor_below_threshold(sensor_below_threshold), .coil_pwm_output(coil_pwm_output),
  .status(status));

// ### dv/levpwm_sensor.sv
/* Hall sensor and comparator model.
   Assumes the bench sets the magnet gap just after a clock edge. */
`timescale 1ns/1ps
// ****
// Sensor model
// ****
module levpwm_sensor #(
  parameter logic [7:0] THRESH = 8'h20
) (
  input wire logic [7:0] gap,
  output logic [7:0] sample,
  output logic below
);
  // Reading rises with the gap, so no magnet gives full scale
  assign sample = gap;
  assign below = gap < THRESH;
endmodule : levpwm_sensor

// ### dv/levpwm_top_test.sv
/* Self-checking bench for levpwm_top.
   Assumes short sim counts for pulse limit, hold and startup. */
`timescale 1ns/1ps
// ****
// Bench
// ****
module levpwm_top_test;
  import levpwm_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, below, coil;
  logic [7:0] gap = 8'hff, smp;
  logic [4:0] frozen;
  levpwm_status_t st;
  int num_errors = 0, checks_done = 0, seed = 32'h5bf3, n;
  logic [7:0] vals [8] = '{8'h00, 8'h01, 8'h80, 8'hfe, 0, 0, 0, 0};
  always #4 clk = ~clk;
  levpwm_sensor u_levpwm_sensor (.gap(gap), .sample(smp), .below(below));
  levpwm_top #(.PULSE_LIMIT_CYCLES(300), .HOLD_CYCLES(50), .STARTUP_CYCLES(40)) u_levpwm_top (
    .clk(clk), .resetn(resetn), .ce(ce), .sensor_sample(smp),
    .sensor_below_threshold(below), .coil_pwm_output(coil), .status(st));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic count_high(input int k);
    n = 0;
    repeat (k)
    begin
      cyc(1);
      n += coil;
    end
  endtask : count_high
  // Full scale is treated as always on
  function automatic logic [8:0] exp_duty(input logic [7:0] s);
    return (s == 8'hff) ? 9'h100 : {1'b0, s};
  endfunction : exp_duty
  task automatic finish_test;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    for (int i = 4; i < 8; i++)
      vals[i] = 8'($random(seed)) & 8'hfe;
    cyc(8);
    resetn = 1;
    count_high(36);
    check("startup", 9'(n), 9'h0);
    check("blank", 9'(st.startup_blank), 9'h1);
    $display("Test startup done");
    cyc(20);
    foreach (vals[i])
    begin
      gap = vals[i];
      cyc(260);
      count_high(256);
      check("duty", 9'(n), exp_duty(vals[i]));
    end
    // Park the compare low first so the full-scale pulse starts from a known edge
    gap = 8'h00;
    cyc(4);
    gap = 8'hff;
    cyc(2);
    count_high(256);
    check("full", 9'(n), 9'h100);
    check("status coil", 9'(st.coil_pwm_output), 9'h1);
    check("drive on", 9'(st.drive_enabled), 9'h1);
    $display("Test duty done");
    for (n = 0; n < 400 && !st.shutdown_latch; n++) cyc(1);
    check("latch", 9'(st.shutdown_latch), 9'h1);
    check("coil off", 9'(coil), 9'h0);
    check("drive off", 9'(st.drive_enabled), 9'h0);
    gap = 8'h10;
    cyc(40);
    gap = 8'h80;
    cyc(1);
    gap = 8'h10;
    cyc(45);
    check("held", 9'(st.shutdown_latch), 9'h1);
    for (n = 0; n < 20 && st.shutdown_latch; n++) cyc(1);
    check("released", 9'(st.shutdown_latch), 9'h0);
    check("drive back", 9'(st.drive_enabled), 9'h1);
    $display("Test watchdog done");
    // A live ramp at half scale would toggle the coil inside the frozen window
    gap = 8'h80;
    cyc(300);
    ce = 0;
    frozen = {coil, st};
    cyc(150);
    check("freeze", 9'({coil, st}), 9'(frozen));
    ce = 1;
    cyc(2);
    $display("Test freeze done");
    finish_test();
  end
  initial
  begin
    #200us;
    num_errors++;
    finish_test();
  end
endmodule : levpwm_top_test
